// ==== hw/mdsp_pkg.sv ====
// shared constants for the motor driver serial register port
package mdsp_pkg;
	localparam int BYTE_BITS = 8;
	localparam int CTRL_NUM = 4;
	localparam int STAT_NUM = 4;
	localparam int STAT_BITS = 7;
	localparam int ADDR_BITS = 5;
	localparam int LEN_BITS = 5;
	localparam int CMD_BIT_POS = 7;
	localparam int PARITY_POS = 7;

	// register map
	localparam logic [4:0] CTRL_BASE = 5'h00;
	localparam logic [4:0] STATUS_WORD_0 = 5'h04;
	localparam logic [4:0] STATUS_WORD_1 = 5'h05;
	localparam logic [4:0] STATUS_WORD_2 = 5'h06;
	localparam logic [4:0] STATUS_WORD_3 = 5'h07;

	// packet framing
	localparam logic [4:0] WRITE_PACKET_BITS = 5'h10;
	localparam logic [4:0] FIRST_BYTE_BITS = 5'h08;
	localparam logic [4:0] LEN_FIRST = 5'h01;
	localparam logic [4:0] LEN_MAX = 5'h1f;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [6:0] STAT_RST = 7'h00;
	localparam logic [7:0] TX_IDLE = 8'hff;
	localparam logic [7:0] UNMAPPED_VAL = 8'h00;

	// status bits that pull the fault pin, per status word
	localparam logic [27:0] FAULT_MASK = 28'hfffffff;
endpackage

// ==== hw/mdsp_port.sv ====
// serial register port of the motor driver, slave side
`timescale 1ns/10ps

// Behaviour
// R1: mode 0: shift out falling, sample rising
// R2: active-low select; output released when deselected
// R3: master keeps serial clock low idle
// R4: bytes msb first; packet spans select low
// R5: first byte: command bit, five-bit address
// R6: eighth falling edge loads addressed register
// R7: read data follows; incoming byte is command
// R8: status bit seven is even parity
// R9: master rereads status on parity error
// R10: control registers read without parity
// R11: back-to-back commands under one select
// R12: reading status clears its latched flags
// R13: updates only on system clock, select high
// R14: master raises select after status read
// R15: write commits after select rises
// R16: each byte returns last addressed register; the port sends TX_IDLE as each packet's first byte
// R17: write commits only at exactly sixteen bits
// R18: writes to read-only registers ignored
// R19: master ignores first byte after power-on
// R20: control registers read/write, reset zero
// R21: four read-only status words, reset zero
// R22: fault output low when status flag set
// R23: hard reset input clears all registers
// R24: select fall restarts bit and byte framing
// R25: link data crosses safely before updates
module mdsp_port (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic hard_reset_in_i,
	input wire logic spi_clk_i,
	input wire logic select_n_i,
	input wire logic serial_in_pin_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	output logic fault_out_n_o,
	input wire logic [mdsp_pkg::STAT_NUM*mdsp_pkg::STAT_BITS-1:0] status_event_i,
	output logic [mdsp_pkg::CTRL_NUM*mdsp_pkg::BYTE_BITS-1:0] ctrl_word_o
);
	import mdsp_pkg::*;

	function automatic logic is_ctrl(input logic [4:0] a);
		is_ctrl = (a[4:2] == CTRL_BASE[4:2]);
	endfunction

	function automatic logic is_status(input logic [4:0] a);
		is_status = (a[4:2] == STATUS_WORD_0[4:2]);
	endfunction

	function automatic logic [7:0] reg_value(input logic [4:0] a, input logic [31:0] c,
		input logic [27:0] s);
		logic [6:0] w;
		w = s[a[1:0]*7 +: 7];
		if (is_ctrl(a)) begin
			reg_value = c[{a[1:0], 3'h0} +: 8]; // R10
		end else if (is_status(a)) begin
			reg_value = {^w, w}; // R8
		end else begin
			reg_value = UNMAPPED_VAL;
		end
	endfunction

	// link domain: receive side
	logic start_q;
	logic [2:0] bitpos_q;
	logic [4:0] len_q;
	logic [6:0] shift_q;
	logic byte_end_q;
	logic expect_cmd_q;
	logic cmd_q;
	logic [4:0] addr_q;
	logic [7:0] wdata_q;
	logic [2:0] bit_idx;
	logic expect_cmd;
	logic [7:0] rx_byte;

	// link domain: transmit side
	logic [7:0] tx_q;
	logic loaded_q;
	logic [3:0] rdmask_q;
	logic [3:0] rd_hit;

	// system domain
	logic sel_s1_q, sel_s2_q, sel_s3_q;
	logic hr_s1_q, hr_s2_q;
	logic rst_all;
	logic sel_rise;
	logic [31:0] ctrl_q;
	logic [27:0] st_q;
	logic [27:0] pend_q;
	logic fault_q;

	// select high is the async restart of the framing
	always_ff @(posedge spi_clk_i or posedge select_n_i) begin
		if (select_n_i) begin
			start_q <= 1'b1; // R24
		end else begin
			start_q <= 1'b0;
		end
	end

	assign bit_idx = start_q ? BIT_FIRST : bitpos_q; // R24
	assign expect_cmd = start_q ? 1'b1 : expect_cmd_q;
	assign rx_byte = {shift_q, serial_in_pin_i}; // R4

	// counters stay put after select rises so the system side can read them
	always_ff @(posedge spi_clk_i) begin
		bitpos_q <= bit_idx + 3'h1;
		byte_end_q <= (bit_idx == BIT_LAST);
		shift_q <= rx_byte[6:0]; // R1
		if (start_q) begin
			len_q <= LEN_FIRST;
		end else if (len_q != LEN_MAX) begin
			len_q <= len_q + 5'h01;
		end
	end

	always_ff @(posedge spi_clk_i) begin
		if (bit_idx == BIT_LAST) begin
			if (expect_cmd) begin
				cmd_q <= rx_byte[CMD_BIT_POS]; // R5
				addr_q <= rx_byte[ADDR_BITS-1:0];
				expect_cmd_q <= ~rx_byte[CMD_BIT_POS]; // R11
			end else begin
				wdata_q <= rx_byte;
				expect_cmd_q <= 1'b1; // R7
			end
		end else begin
			expect_cmd_q <= expect_cmd;
		end
	end

	// registers read here only change while select is high, so they are still now
	always_ff @(negedge spi_clk_i or posedge select_n_i) begin
		if (select_n_i) begin
			tx_q <= TX_IDLE;
			loaded_q <= 1'b0;
		end else if (byte_end_q) begin
			tx_q <= reg_value(addr_q, ctrl_q, st_q); // R6 R16
			loaded_q <= 1'b1;
		end else begin
			tx_q <= {tx_q[6:0], 1'b1}; // R1
			loaded_q <= 1'b0;
		end
	end

	assign rd_hit = (byte_end_q && is_status(addr_q)) ? (4'h1 << addr_q[1:0]) : 4'h0;

	always_ff @(negedge spi_clk_i) begin
		rdmask_q <= ((len_q == LEN_FIRST) ? 4'h0 : rdmask_q) | rd_hit; // R12
	end

	assign serial_out_o = tx_q[7]; // R4
	assign serial_out_oe_o = ~select_n_i; // R2

	// system domain synchronisers
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			sel_s3_q <= 1'b1;
			hr_s1_q <= 1'b0;
			hr_s2_q <= 1'b0;
		end else begin
			sel_s1_q <= select_n_i;
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
			hr_s1_q <= hard_reset_in_i;
			hr_s2_q <= hr_s1_q;
		end
	end

	assign rst_all = rst_i | hr_s2_q; // R23
	// link clock is idle once select is high, so its registers are read whole
	assign sel_rise = sel_s2_q & ~sel_s3_q; // R25

	always_ff @(posedge mclk_i) begin
		if (rst_all) begin
			ctrl_q <= {CTRL_NUM{CTRL_RST}}; // R20
		end else if (sel_rise && len_q == WRITE_PACKET_BITS && cmd_q && is_ctrl(addr_q)) begin
			ctrl_q[{addr_q[1:0], 3'h0} +: 8] <= wdata_q; // R15 R17 R18
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < STAT_NUM; gi++) begin : g_stat
			logic [6:0] ev;
			logic [6:0] clr;
			assign ev = status_event_i[gi*STAT_BITS +: STAT_BITS];
			assign clr = {STAT_BITS{sel_rise & rdmask_q[gi]}};
			// events arriving under select are held, not dropped
			always_ff @(posedge mclk_i) begin
				if (rst_all) begin
					st_q[gi*STAT_BITS +: STAT_BITS] <= STAT_RST; // R21
					pend_q[gi*STAT_BITS +: STAT_BITS] <= STAT_RST;
				end else if (sel_s2_q) begin
					st_q[gi*STAT_BITS +: STAT_BITS] <= (st_q[gi*STAT_BITS +: STAT_BITS]
						& ~clr) | pend_q[gi*STAT_BITS +: STAT_BITS] | ev; // R12 R13
					pend_q[gi*STAT_BITS +: STAT_BITS] <= STAT_RST;
				end else begin
					pend_q[gi*STAT_BITS +: STAT_BITS] <= pend_q[gi*STAT_BITS +: STAT_BITS]
						| ev;
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk_i) begin
		if (rst_all) begin
			fault_q <= 1'b0;
		end else if (sel_s2_q) begin
			fault_q <= |(st_q & FAULT_MASK); // R22 R13
		end
	end

	assign fault_out_n_o = ~fault_q;
	assign ctrl_word_o = ctrl_q;

	sequence s_sel_rise;
		sel_s2_q && !sel_s3_q;
	endsequence

	sequence s_good_write;
		s_sel_rise ##0 (len_q == WRITE_PACKET_BITS && cmd_q && is_ctrl(addr_q));
	endsequence

	property p_fault_follow;
		@(posedge mclk_i) disable iff (rst_all)
		sel_s2_q |=> (fault_out_n_o == !$past(|(st_q & FAULT_MASK)));
	endproperty
	a_fault_follow: assert property (p_fault_follow) else $error("fault pin wrong"); // R22

	property p_ctrl_hold;
		@(posedge mclk_i) disable iff (rst_all)
		!sel_s2_q |=> $stable(ctrl_q);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved under select"); // R13

	property p_status_hold;
		@(posedge mclk_i) disable iff (rst_all)
		(!sel_s2_q ##1 !sel_s2_q) |-> $stable(st_q);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status moved under select"); // R13

	property p_commit;
		@(posedge mclk_i) disable iff (rst_all)
		s_good_write |=> (ctrl_q[{$past(addr_q[1:0]), 3'h0} +: 8] == $past(wdata_q));
	endproperty
	a_commit: assert property (p_commit) else $error("write not committed"); // R15

	property p_discard;
		@(posedge mclk_i) disable iff (rst_all)
		s_sel_rise ##0 (len_q != WRITE_PACKET_BITS) |=> $stable(ctrl_q);
	endproperty
	a_discard: assert property (p_discard) else $error("bad length write committed"); // R17

	property p_read_only;
		@(posedge mclk_i) disable iff (rst_all)
		s_sel_rise ##0 !is_ctrl(addr_q) |=> $stable(ctrl_q);
	endproperty
	a_read_only: assert property (p_read_only) else $error("read-only write took effect"); // R18

	property p_parity;
		@(posedge spi_clk_i) disable iff (select_n_i)
		(loaded_q && is_status(addr_q)) |-> (^tx_q == 1'b0);
	endproperty
	a_parity: assert property (p_parity) else $error("status parity wrong"); // R8

	property p_clear;
		@(posedge mclk_i) disable iff (rst_all)
		s_sel_rise ##0 (rdmask_q[0] && pend_q[6:0] == 7'h00 && status_event_i[6:0] == 7'h00)
		|=> (st_q[6:0] == 7'h00);
	endproperty
	a_clear: assert property (p_clear) else $error("status not cleared by read"); // R12

	property p_msb_shift;
		@(negedge spi_clk_i) disable iff (select_n_i)
		!byte_end_q ##1 !byte_end_q |-> (serial_out_o == $past(tx_q[6]));
	endproperty
	a_msb_shift: assert property (p_msb_shift) else $error("output not shifted msb first"); // R4
endmodule

// ==== sim/mdsp_link_master.sv ====
// serial link master model driving the register port
`timescale 1ns/10ps
module mdsp_link_master (
	output logic spi_clk_o,
	output logic select_n_o,
	output logic serial_in_o,
	input wire logic line_i
);
	initial begin
		spi_clk_o = 1'b0;
		select_n_o = 1'b1;
		serial_in_o = 1'b0;
	end
	// n bits msb first under one select; clock stands still outside frames
	task automatic xfer(input logic [23:0] d, input int n, output logic [23:0] r);
		r = '0;
		#37;
		select_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in_o = d[i];
			#80;
			spi_clk_o = 1'b1;
			r = {r[22:0], line_i};
			#80;
			spi_clk_o = 1'b0;
		end
		// released data line must not keep its last value
		serial_in_o = ~serial_in_o;
		#80;
		select_n_o = 1'b1;
		#800;
	endtask
endmodule

// ==== sim/mdsp_port_bench.sv ====
// bench for the motor driver serial register port
`timescale 1ns/10ps
module mdsp_port_bench;
	import mdsp_pkg::*;
	logic mclk_i, rst_i, hard_reset_in, spi_clk, select_n, serial_in;
	logic serial_out, serial_out_oe, fault_out_n;
	logic [27:0] status_event;
	logic [31:0] ctrl_word;
	logic [23:0] r;
	wire logic line;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	// external pull-up when the port lets go
	assign line = serial_out_oe ? serial_out : 1'b1;
	mdsp_port dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .hard_reset_in_i(hard_reset_in),
		.spi_clk_i(spi_clk), .select_n_i(select_n), .serial_in_pin_i(serial_in),
		.serial_out_o(serial_out), .serial_out_oe_o(serial_out_oe),
		.fault_out_n_o(fault_out_n), .status_event_i(status_event), .ctrl_word_o(ctrl_word));
	mdsp_link_master master_u (.spi_clk_o(spi_clk), .select_n_o(select_n),
		.serial_in_o(serial_in), .line_i(line));
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic pulse(input logic [27:0] ev);
		@(posedge mclk_i);
		#1 status_event = ev;
		@(posedge mclk_i);
		#1 status_event = '0;
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic t_reset();
		check({31'h0, line}, 32'h1);
		check(ctrl_word, 32'h0);
		check({31'h0, fault_out_n}, 32'h1);
	endtask
	// first returned byte of each packet is never judged
	task automatic t_write();
		master_u.xfer(24'h0082a5, 16, r);
		check({24'h0, r[7:0]}, 32'h0);
		check({24'h0, ctrl_word[23:16]}, 32'ha5);
		master_u.xfer(24'h000200, 16, r);
		check({24'h0, r[7:0]}, 32'ha5);
		// second write to the same word must hand back the earlier data
		master_u.xfer(24'h0082c3, 16, r);
		check({24'h0, r[7:0]}, 32'ha5);
		check({24'h0, ctrl_word[23:16]}, 32'hc3);
		master_u.xfer(24'h815a00, 24, r);
		master_u.xfer(24'h000081, 8, r);
		check({24'h0, ctrl_word[15:8]}, 32'h0);
	endtask
	task automatic t_status();
		pulse(28'h0000181);
		check({31'h0, fault_out_n}, 32'h0);
		master_u.xfer(24'h040500, 24, r);
		check({24'h0, r[15:8]}, 32'h81);
		check({31'h0, ^r[15:8]}, 32'h0);
		check({24'h0, r[7:0]}, 32'h03);
		check({31'h0, fault_out_n}, 32'h1);
		master_u.xfer(24'h000400, 16, r);
		check({24'h0, r[7:0]}, 32'h0);
	endtask
	// event under select is held back, then applied once select is high
	task automatic t_pend();
		fork
			master_u.xfer(24'h000000, 16, r);
			begin
				@(negedge select_n);
				repeat (4) @(posedge mclk_i);
				#1 status_event = 28'h0004000;
				@(posedge mclk_i);
				#1 status_event = '0;
				repeat (2) @(posedge mclk_i);
				check({31'h0, fault_out_n}, 32'h1);
			end
		join
		check({31'h0, fault_out_n}, 32'h0);
		master_u.xfer(24'h000600, 16, r);
		check({24'h0, r[7:0]}, 32'h81);
		check({31'h0, fault_out_n}, 32'h1);
	endtask
	task automatic t_readonly();
		master_u.xfer(24'h00847f, 16, r);
		check(ctrl_word, 32'h00c30000);
		master_u.xfer(24'h000400, 16, r);
		check({24'h0, r[7:0]}, 32'h0);
		check({31'h0, fault_out_n}, 32'h1);
	endtask
	task automatic t_hard();
		@(posedge mclk_i);
		#1 hard_reset_in = 1'b1;
		repeat (4) @(posedge mclk_i);
		#1 hard_reset_in = 1'b0;
		repeat (4) @(posedge mclk_i);
		check(ctrl_word, 32'h0);
	endtask
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		rst_i = 1'b1;
		hard_reset_in = 1'b0;
		status_event = '0;
		repeat (5) @(posedge mclk_i);
		#1 rst_i = 1'b0;
		repeat (2) @(posedge mclk_i);
		t_reset();
		t_write();
		t_status();
		t_pend();
		t_readonly();
		t_hard();
		summarize();
	end
endmodule
